// ### rtl/cantxm_flags.v
// Purpose: transmit mailbox status and control flags behind an APB slave
// Assumes: pclk 125 MHz, presetn asynchronous active low, transmit engine outside
// Notes: zero-wait APB slave; unmapped addresses read zero with pslverr high
`timescale 1ns/1ps
`default_nettype none
`include "cantxm_regs.vh"
module cantxm_flags
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // engine side for mailbox 2
  input wire mbox2_done,
  input wire mbox2_ok,
  input wire mbox2_arb_lost,
  input wire mbox2_error,
  input wire mbox2_tx_start,
  // engine side for mailbox 1, then the request outputs for both mailboxes
  input wire mbox1_idle,
  output reg mbox2_tx_request,
  output reg mbox1_tx_request,
  output reg mbox1_cancel_request
);

  // ==========================================================
  // state
  reg mbox2_tx_success_flag;
  reg mbox2_tx_complete_flag;
  reg mbox2_arbitration_lost_flag;
  reg mbox2_tx_error_flag;

  // ==========================================================
  // decode
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire hit_sts = (paddr == `CANTXM_STS_OFF);
  wire hit_ctl = (paddr == `CANTXM_CTL_OFF);
  wire wr_sts = wr_acc & hit_sts;
  wire wr_ctl = wr_acc & hit_ctl;
  // new mailbox 2 request accepted from software
  wire req2_new = wr_ctl & pwdata[`CANTXM_REQ2_BIT];
  // completion clear by software or by a new request
  wire tcf_clr = (wr_sts & pwdata[`CANTXM_TCF_BIT]) | req2_new;
  wire tsf_clr = (wr_sts & pwdata[`CANTXM_TSF_BIT]) | tcf_clr;
  wire alf_clr = (wr_sts & pwdata[`CANTXM_ALF_BIT]) | tcf_clr | mbox2_tx_start;
  wire err_clr = (wr_sts & pwdata[`CANTXM_ERR_BIT]) | tcf_clr;

  // ==========================================================
  // status image, reserved bits read zero
  function [31:0] sts_image;
    input a, s, c, e, k;
    begin
      sts_image = `CANTXM_STS_RST;
      sts_image[`CANTXM_ERR_BIT] = e;
      sts_image[`CANTXM_ALF_BIT] = a;
      sts_image[`CANTXM_TSF_BIT] = s;
      sts_image[`CANTXM_TCF_BIT] = c;
      sts_image[`CANTXM_CT1_BIT] = k;
    end
  endfunction

  // ==========================================================
  // mailbox 2 flags; a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mbox2_tx_success_flag <= 1'b0;
      mbox2_tx_complete_flag <= 1'b0;
      mbox2_arbitration_lost_flag <= 1'b0;
      mbox2_tx_error_flag <= 1'b0;
    end
    else
    begin
      if (mbox2_done)
      begin
        mbox2_tx_complete_flag <= 1'b1;
        mbox2_tx_success_flag <= mbox2_ok;
      end
      else
      begin
        if (tcf_clr)
          mbox2_tx_complete_flag <= 1'b0;
        if (tsf_clr)
          mbox2_tx_success_flag <= 1'b0;
      end
      if (mbox2_arb_lost)
        mbox2_arbitration_lost_flag <= 1'b1;
      else if (alf_clr)
        mbox2_arbitration_lost_flag <= 1'b0;
      if (mbox2_error)
        mbox2_tx_error_flag <= 1'b1;
      else if (err_clr)
        mbox2_tx_error_flag <= 1'b0;
    end
  end

  // ==========================================================
  // requests; cancel is write-one-to-set, held until mailbox 1 idles
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mbox1_cancel_request <= 1'b0;
      mbox1_tx_request <= 1'b0;
      mbox2_tx_request <= 1'b0;
    end
    else
    begin
      if (wr_sts & pwdata[`CANTXM_CT1_BIT])
        mbox1_cancel_request <= 1'b1;
      else if (mbox1_idle)
        mbox1_cancel_request <= 1'b0;
      // request pulses for one cycle; engine latches it
      mbox2_tx_request <= req2_new;
      mbox1_tx_request <= wr_ctl & pwdata[`CANTXM_REQ1_BIT];
    end
  end

  // ==========================================================
  // apb answer, zero wait; registered so outputs come from flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // pready rises in the cycle after setup, ending access in 2nd cycle
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(hit_sts | hit_ctl);
      if (psel & ~penable & ~pwrite & hit_sts)
        prdata <= sts_image(mbox2_arbitration_lost_flag, mbox2_tx_success_flag,
          mbox2_tx_complete_flag, mbox2_tx_error_flag, mbox1_cancel_request);
      else
        prdata <= 32'h0000_0000;
    end
  end

endmodule // cantxm_flags
`default_nettype wire

// ### rtl/cantxm_regs.vh
// Purpose: register map and field positions of the mailbox status flags
// Assumes: APB with 32-bit data, word-aligned registers
// Notes: definitions only
`ifndef CANTXM_REGS_VH
`define CANTXM_REGS_VH
// ==========================================================
// offsets
`define CANTXM_STS_OFF 12'h008
`define CANTXM_CTL_OFF 12'h000
// ==========================================================
// status register fields
`define CANTXM_ALF_BIT 18
`define CANTXM_TSF_BIT 17
`define CANTXM_TCF_BIT 16
`define CANTXM_CT1_BIT 15
`define CANTXM_ERR_BIT 19
// ==========================================================
// control register fields
`define CANTXM_REQ2_BIT 0
`define CANTXM_REQ1_BIT 1
// ==========================================================
// reset values
`define CANTXM_STS_RST 32'h0000_0000
`endif

// ### tb/cantxm_monitor.sv
// Purpose: port checker. Assumes: pclk only. Notes: bound below.
`timescale 1ns/1ps
`default_nettype none
module cantxm_monitor(input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  mbox2_done, mbox2_ok, mbox1_idle, mbox2_tx_request, mbox1_cancel_request, mbox1_tx_request,
  input wire logic [11:0] paddr, input wire logic [31:0] pwdata, prdata);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access-phase write, and a status read set up right after a finish
  wire wr = psel && penable && pwrite;
  sequence s_done; mbox2_done ##1 psel && !penable && !pwrite && paddr == 12'h008; endsequence
  AST_ANS: assert property (psel && !penable |=> pready) else $error("late");
  AST_ONE: assert property (pready |=> !pready) else $error("long");
  AST_IDLE: assert property (!pready |-> !prdata) else $error("data");
  AST_MAP: assert property (pready && paddr[2] |-> pslverr) else $error("map");
  AST_CAN: assert property (wr && paddr == 12'h008 && pwdata[15]
    |=> mbox1_cancel_request) else $error("set");
  AST_KEEP: assert property ($fell(mbox1_cancel_request) |-> $past(mbox1_idle))
    else $error("drop");
  AST_REQ: assert property (wr && paddr == 12'h000 && pwdata[0] |=> mbox2_tx_request)
    else $error("req");
  AST_REQ1: assert property (wr && paddr == 12'h000 && pwdata[1] |=> mbox1_tx_request)
    else $error("req1");
  AST_DONE: assert property (s_done |=> prdata[16]
    && prdata[17] == $past(mbox2_ok, 2)) else $error("done");
endmodule // cantxm_monitor
bind cantxm_flags cantxm_monitor u_mon(.*);
`default_nettype wire

// ### tb/cantxm_engine.sv
// Purpose: engine model. Assumes: one job. Notes: a failure is lost arbitration.
`timescale 1ns/1ps
`default_nettype none
module cantxm_engine(input wire logic pclk, presetn, mbox2_tx_request, mbox1_cancel_request,
  mbox2_ok, output logic mbox2_tx_start, mbox2_done, mbox2_arb_lost, mbox1_idle);
  // start, finish a cycle later; an abort idles mailbox 1 one cycle after the cancel request
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {mbox2_tx_start, mbox2_done, mbox2_arb_lost, mbox1_idle} <= 4'h0;
    else {mbox2_tx_start, mbox2_done, mbox2_arb_lost, mbox1_idle} <= {mbox2_tx_request,
      mbox2_tx_start, mbox2_tx_start && !mbox2_ok, mbox1_cancel_request};
endmodule // cantxm_engine
`default_nettype wire

// ### tb/can_tx_mailbox_status_flags_bench.sv
// Purpose: flag bench. Assumes: pclk 8 ns. Notes: reads noted in a queue.
`timescale 1ns/1ps
`default_nettype none
module can_tx_mailbox_status_flags_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mbox2_ok = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [15:0] r = 16'h47fa;
  logic [32:0] q[$];
  logic pready, pslverr, mbox2_tx_start, mbox2_done, mbox2_arb_lost, mbox1_idle;
  logic mbox2_tx_request, mbox1_cancel_request, mbox1_tx_request, mbox2_error;
  int n_fail = 0, checks_done = 0;
  // a lost arbitration is also reported as an error, so the error flag is exercised
  assign mbox2_error = mbox2_arb_lost;
  cantxm_flags u_dut(.*);
  cantxm_engine u_eng(.*);
  initial forever #4 pclk = ~pclk;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task check(input logic [32:0] got, exp);
    checks_done++;
    n_fail += int'(got !== exp);
    if (got !== exp) $display("CHECK FAILED at %0t: got %h", $time, got);
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int k = 0;
    if (!w) q.push_back(e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk) k++; while (pready !== 1'b1 && k < 20);
    {psel, penable} <= 2'b00;
    n_fail += int'(k == 20);
    if (k == 20) report_and_stop;
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, q.pop_front());
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h008, '0, '0);
    apb(0, 12'h004, '0, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      r = lfsr(r);
      mbox2_ok <= r[0];
      apb(1, 12'h000, 32'h0000_0001, '0);
      repeat (2) @(posedge pclk);
      apb(0, 12'h008, '0, {13'h0, !r[0], !r[0], r[0], 17'h1_0000});
      apb(1, 12'h008, 32'h0002_0000, '0);
      apb(0, 12'h008, '0, {13'h0, !r[0], !r[0], 18'h1_0000});
      apb(1, 12'h008, 32'h0001_0000, '0);
      apb(0, 12'h008, '0, '0);
      $display("round %0d", i);
    end
    apb(1, 12'h000, 32'h0000_0002, '0);
    apb(1, 12'h008, 32'h0000_8000, '0);
    report_and_stop;
  end
endmodule // can_tx_mailbox_status_flags_bench
`default_nettype wire
